// ### hdl/obd_defines.vh
// Constants for the option byte configuration decoder
`ifndef OBD_DEFINES_VH
`define OBD_DEFINES_VH

// ****************************************
// Avalon register offsets (byte addresses)
// ****************************************
`define OBD_ADDR_OPT0     4'h0
`define OBD_ADDR_OPT1     4'h4
`define OBD_ADDR_STATUS   4'h8
`define OBD_ADDR_CONTROL  4'hc

// ****************************************
// Option byte 0 and 1 field positions
// ****************************************
`define OBD_O0_PROT_BIT   0
`define OBD_O1_REMAP_HI   7
`define OBD_O1_REMAP_LO   6
`define OBD_O1_SRC_HI     5
`define OBD_O1_SRC_LO     4
`define OBD_O1_RNG_HI     3
`define OBD_O1_RNG_LO     2
`define OBD_O1_RESET_DELAY_SEL_BIT   0

// ****************************************
// Reset values (erased option bytes)
// ****************************************
`define OBD_OPT0_DEFAULT  8'hff
`define OBD_OPT1_DEFAULT  8'hef

// ****************************************
// Clock source and range codes
// ****************************************
`define OBD_SRC_RESONATOR 2'h0
`define OBD_SRC_RESERVED  2'h1
`define OBD_SRC_INTERNAL  2'h2
`define OBD_SRC_EXTERNAL  2'h3
`define OBD_RNG_LOW       2'h0
`define OBD_RNG_MID_LOW   2'h1
`define OBD_RNG_MID_HIGH  2'h2
`define OBD_RNG_HIGH      2'h3

// ****************************************
// Delay counts in CPU cycles
// ****************************************
`define OBD_DELAY_LONG    13'h1000
`define OBD_DELAY_SHORT   13'h0100

`endif

// ### hdl/obd_delay_counter.v
// Reset and halt-exit delay counter
`timescale 1ns/1ps
`include "obd_defines.vh"
module obd_delay_counter (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Control
  input  wire        start,
  input  wire        short_sel,
  // Status
  output wire        busy
);
  reg  [12:0] count_reg;
  reg  [12:0] count_next;

  always @* begin
    count_next = count_reg;
    if (start) begin
      count_next = short_sel ? `OBD_DELAY_SHORT : `OBD_DELAY_LONG;
    end else if (count_reg != 13'h0000) begin
      count_next = count_reg - 13'h0001;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      count_reg <= 13'h0000;
    end else begin
      count_reg <= count_next;
    end
  end

  assign busy = (count_reg != 13'h0000);
endmodule // obd_delay_counter

// ### hdl/obd_option_decoder.v
// Option byte store, decoder, pin routing and Avalon slave
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "obd_defines.vh"
module obd_option_decoder (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Avalon-MM slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output reg  [1:0]  avs_response,
  // Programming tool port
  input  wire        prog_mode,
  input  wire        prog_opt_we,
  input  wire        prog_opt_sel,
  input  wire [7:0]  prog_opt_data,
  input  wire        prog_opt_erase,
  input  wire        prog_mem_read_req,
  input  wire        prog_mem_write_req,
  // User memory erase engine
  output reg         user_mem_erase,
  input  wire        user_mem_erase_done,
  // Protection effects
  output reg         readout_protect_n,
  output wire        ext_read_allow,
  output wire        flash_write_allow,
  // Halt exit request
  input  wire        halt_exit,
  output wire        cpu_hold,
  // Decoded configuration
  output reg  [1:0]  alt_function_remap,
  output reg  [1:0]  clock_source_sel,
  output reg  [1:0]  osc_freq_range,
  output reg         reset_delay_sel,
  output reg  [3:0]  clock_range_onehot,
  output reg         clk_src_resonator,
  output reg         clk_src_internal,
  output reg         clk_src_external,
  output reg         clk_src_reserved,
  // Timer and serial functions
  input  wire        timer_cmp_out1,
  input  wire        timer_cmp_out2,
  output wire        timer_cap_in1,
  output wire        timer_cap_in2,
  input  wire        serial2_clk,
  input  wire        serial2_tx,
  output wire        serial2_rx,
  output wire        serial2_avail,
  // Port pins, split into in, out and enable
  input  wire [7:0]  port_pin_in,
  output reg  [7:0]  port_pin_out,
  output reg  [7:0]  port_pin_oe
);
  // ****************************************
  // Pin index map
  // ****************************************
  localparam PIN_D1 = 0;
  localparam PIN_D3 = 1;
  localparam PIN_D4 = 2;
  localparam PIN_D5 = 3;
  localparam PIN_B6 = 4;
  localparam PIN_B7 = 5;
  localparam PIN_C0 = 6;
  localparam PIN_C1 = 7;

  localparam ST_IDLE  = 2'b00;
  localparam ST_ERASE = 2'b01;
  localparam ST_CLEAR = 2'b10;

  // ****************************************
  // Non-volatile image and latched copy
  // ****************************************
  reg  [7:0] nv_opt0_reg = `OBD_OPT0_DEFAULT;
  reg  [7:0] nv_opt1_reg = `OBD_OPT1_DEFAULT;
  reg  [7:0] live_opt0_reg;
  reg  [7:0] live_opt1_reg;
  reg  [1:0] state_reg;
  reg        sampled_reg;
  reg        rsp_reg;
  reg        bad_key_reg;
  wire [7:0] pin_sync;
  wire       delay_busy;
  wire       prot_active;

  // Synchronise pins that come from outside
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_sync
      obd_pin_sync u_sync (
        .clk       (clk),
        .reset     (reset),
        .pin_in    (port_pin_in[g]),
        .level_out (pin_sync[g])
      );
    end
  endgenerate

  assign prot_active = ~live_opt0_reg[`OBD_O0_PROT_BIT];

  // ****************************************
  // Programming tool writes and erase sequence
  // ****************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg      <= ST_IDLE;
      user_mem_erase <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (prog_mode && prog_opt_erase) begin
            if (~nv_opt0_reg[`OBD_O0_PROT_BIT]) begin
              user_mem_erase <= 1'b1;
              state_reg      <= ST_ERASE;
            end else begin
              state_reg      <= ST_CLEAR;
            end
          end
        end
        ST_ERASE: begin
          if (user_mem_erase_done) begin
            user_mem_erase <= 1'b0;
            state_reg      <= ST_CLEAR;
          end
        end
        ST_CLEAR: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Option store keeps its contents through reset
  always @(posedge clk) begin
    if (state_reg == ST_CLEAR) begin
      nv_opt0_reg <= `OBD_OPT0_DEFAULT;
      nv_opt1_reg <= `OBD_OPT1_DEFAULT;
    end else if ((state_reg == ST_IDLE) && prog_mode && !prog_opt_erase && prog_opt_we && ~prot_active) begin
      if (prog_opt_sel) begin
        nv_opt1_reg <= prog_opt_data;
      end else begin
        nv_opt0_reg <= prog_opt_data;
      end
    end
  end

  // ****************************************
  // Latch at reset release
  // ****************************************
  // sample once after reset
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      live_opt0_reg <= `OBD_OPT0_DEFAULT;
      live_opt1_reg <= `OBD_OPT1_DEFAULT;
      sampled_reg   <= 1'b0;
    end else if (!sampled_reg) begin
      live_opt0_reg <= nv_opt0_reg;
      live_opt1_reg <= nv_opt1_reg;
      sampled_reg   <= 1'b1;
    end
  end

  obd_delay_counter u_delay (
    .clk       (clk),
    .reset     (reset),
    .start     ((~sampled_reg) | halt_exit),
    .short_sel (sampled_reg ? live_opt1_reg[`OBD_O1_RESET_DELAY_SEL_BIT] : nv_opt1_reg[`OBD_O1_RESET_DELAY_SEL_BIT]),
    .busy      (delay_busy)
  );
  assign cpu_hold = delay_busy | ~sampled_reg;

  assign ext_read_allow    = ~prot_active & prog_mem_read_req;
  assign flash_write_allow = ~prot_active & prog_mem_write_req;

  // ****************************************
  // Decoded configuration registers
  // ****************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      readout_protect_n  <= 1'b1;
      alt_function_remap <= 2'h3;
      clock_source_sel   <= `OBD_SRC_INTERNAL;
      osc_freq_range     <= `OBD_RNG_HIGH;
      reset_delay_sel    <= 1'b1;
      clock_range_onehot <= 4'h8;
      clk_src_resonator  <= 1'b0;
      clk_src_internal   <= 1'b1;
      clk_src_external   <= 1'b0;
      clk_src_reserved   <= 1'b0;
    end else begin
      readout_protect_n  <= live_opt0_reg[`OBD_O0_PROT_BIT];
      alt_function_remap <= live_opt1_reg[`OBD_O1_REMAP_HI:`OBD_O1_REMAP_LO];
      clock_source_sel   <= live_opt1_reg[`OBD_O1_SRC_HI:`OBD_O1_SRC_LO];
      osc_freq_range     <= live_opt1_reg[`OBD_O1_RNG_HI:`OBD_O1_RNG_LO];
      reset_delay_sel    <= live_opt1_reg[`OBD_O1_RESET_DELAY_SEL_BIT];
      clock_range_onehot <= 4'h1 << live_opt1_reg[`OBD_O1_RNG_HI:`OBD_O1_RNG_LO];
      clk_src_resonator  <= (live_opt1_reg[`OBD_O1_SRC_HI:`OBD_O1_SRC_LO] == `OBD_SRC_RESONATOR);
      clk_src_reserved   <= (live_opt1_reg[`OBD_O1_SRC_HI:`OBD_O1_SRC_LO] == `OBD_SRC_RESERVED);
      clk_src_internal   <= (live_opt1_reg[`OBD_O1_SRC_HI:`OBD_O1_SRC_LO] == `OBD_SRC_INTERNAL);
      clk_src_external   <= (live_opt1_reg[`OBD_O1_SRC_HI:`OBD_O1_SRC_LO] == `OBD_SRC_EXTERNAL);
    end
  end

  // ****************************************
  // Alternate function routing
  // ****************************************
  // serial 2 available when upper remap set
  assign serial2_avail = alt_function_remap[1];
  assign timer_cap_in1 = alt_function_remap[1] ? pin_sync[PIN_C0] : pin_sync[PIN_D4];
  assign serial2_rx    = alt_function_remap[1] ? pin_sync[PIN_D4] : 1'b1;
  assign timer_cap_in2 = alt_function_remap[0] ? pin_sync[PIN_C1] : pin_sync[PIN_D1];

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      port_pin_out <= 8'h00;
      port_pin_oe  <= 8'h00;
    end else begin
      port_pin_out <= 8'h00;
      port_pin_oe  <= 8'h00;
      if (alt_function_remap[1]) begin
        port_pin_out[PIN_B6] <= timer_cmp_out1;
        port_pin_out[PIN_B7] <= timer_cmp_out2;
        port_pin_out[PIN_D3] <= serial2_clk;
        port_pin_out[PIN_D5] <= serial2_tx;
        port_pin_oe[PIN_B6]  <= 1'b1;
        port_pin_oe[PIN_B7]  <= 1'b1;
        port_pin_oe[PIN_D3]  <= 1'b1;
        port_pin_oe[PIN_D5]  <= 1'b1;
      end else begin
        port_pin_out[PIN_D3] <= timer_cmp_out1;
        port_pin_out[PIN_D5] <= timer_cmp_out2;
        port_pin_oe[PIN_D3]  <= 1'b1;
        port_pin_oe[PIN_D5]  <= 1'b1;
      end
    end
  end

  // ****************************************
  // Avalon-MM slave, read only except writes to CONTROL
  // ****************************************
  assign avs_waitrequest = (avs_read | avs_write) & ~rsp_reg;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rsp_reg      <= 1'b0;
      bad_key_reg  <= 1'b0;
      avs_readdata <= 32'h00000000;
      avs_response <= 2'h0;
    end else begin
      rsp_reg <= (avs_read | avs_write) & ~rsp_reg;
      if ((avs_read | avs_write) & ~rsp_reg) begin
        avs_readdata <= 32'h00000000;
        avs_response <= 2'h0;
        if (avs_write) begin
          if (avs_address == `OBD_ADDR_CONTROL) begin
            bad_key_reg <= 1'b1;
          end else begin
            avs_response <= 2'h2;
          end
        end else if (avs_address == `OBD_ADDR_OPT0) begin
          avs_readdata <= {24'h000000, live_opt0_reg};
        end else if (avs_address == `OBD_ADDR_OPT1) begin
          avs_readdata <= {24'h000000, live_opt1_reg};
        end else if (avs_address == `OBD_ADDR_STATUS) begin
          avs_readdata <= {26'h0000000, bad_key_reg, user_mem_erase, delay_busy, sampled_reg,
                           prot_active, clk_src_reserved};
        end else if (avs_address == `OBD_ADDR_CONTROL) begin
          avs_readdata <= {31'h00000000, bad_key_reg};
        end else begin
          avs_response <= 2'h2;
        end
      end
    end
  end
endmodule // obd_option_decoder

// ### hdl/obd_pin_sync.v
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module obd_pin_sync (
  // Clock and reset
  input  wire clk,
  input  wire reset,
  // Pin side
  input  wire pin_in,
  // Clean level
  output reg  level_out
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end
endmodule // obd_pin_sync

// ### tb/obd_option_checker_sva.sv
// Port checker for the option byte decoder
`timescale 1ns/1ps
module obd_option_checker (
  // Clock and reset
  input wire       clk, reset,
  // Bus
  input wire [3:0] avs_address,
  input wire       avs_write, avs_waitrequest,
  input wire [1:0] avs_response,
  // Tool and protection
  input wire       prog_opt_erase, prog_mem_read_req, prog_mem_write_req, user_mem_erase,
  input wire       readout_protect_n, ext_read_allow, flash_write_allow, cpu_hold,
  // Configuration and pins
  input wire [1:0] alt_function_remap, clock_source_sel, osc_freq_range,
  input wire       reset_delay_sel, clk_src_resonator, clk_src_external, serial2_avail,
  input wire       timer_cmp_out1, serial2_clk,
  input wire [7:0] port_pin_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  reg [12:0] hold_cnt;
  reg [1:0]  rel_cnt;
  // Hold length and settle counters
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_cnt <= 13'h0;
      rel_cnt  <= 2'h0;
    end else begin
      hold_cnt <= cpu_hold ? hold_cnt + 13'h1 : 13'h0;
      rel_cnt  <= user_mem_erase ? 2'h0 : rel_cnt + {1'b0, rel_cnt != 2'h3};
    end
  end
  read_gate_a: assert property (prog_mem_read_req |=> readout_protect_n == $past(ext_read_allow))
    else $error("read gate wrong");
  flash_gate_a: assert property (prog_mem_write_req |=> readout_protect_n == $past(flash_write_allow))
    else $error("write gate wrong");
  block_all_a: assert property (!readout_protect_n |-> !flash_write_allow && !ext_read_allow)
    else $error("protected access let through");
  serial_avail_a: assert property (serial2_avail == alt_function_remap[1])
    else $error("serial availability wrong");
  d3_timer_a: assert property (!$past(reset) && !$past(alt_function_remap[1])
    |-> port_pin_out[1] == $past(timer_cmp_out1)) else $error("line 3 not compare 1");
  d3_serial_a: assert property (!$past(reset) && $past(alt_function_remap[1])
    |-> port_pin_out[1] == $past(serial2_clk)) else $error("line 3 not serial clock");
  b6_timer_a: assert property (!$past(reset) && $past(alt_function_remap[1])
    |-> port_pin_out[4] == $past(timer_cmp_out1)) else $error("port b 6 not compare 1");
  src_decode_a: assert property (clk_src_external == (clock_source_sel == 2'h3)
    && clk_src_resonator == (clock_source_sel == 2'h0)) else $error("source flags wrong");
  hold_len_a: assert property ($fell(cpu_hold) |-> (reset_delay_sel ?
    (hold_cnt >= 13'h100 && hold_cnt <= 13'h102) : (hold_cnt >= 13'h1000 && hold_cnt <= 13'h1002)))
    else $error("hold length wrong");
  cfg_hold_a: assert property (rel_cnt == 2'h3 |-> $stable({alt_function_remap, clock_source_sel,
    osc_freq_range, reset_delay_sel, readout_protect_n})) else $error("configuration moved");
  opt_write_a: assert property (avs_write && !avs_waitrequest && avs_address != 4'hc
    |-> avs_response == 2'h2) else $error("option write accepted");
  erase_first_a: assert property ($rose(user_mem_erase) |-> $past(prog_opt_erase) && !readout_protect_n)
    else $error("erase without cause");
endmodule // obd_option_checker
bind obd_option_decoder obd_option_checker chk_i (.*);

// ### tb/obd_prog_tool.sv
// Programming tool model for option bytes and erase
`timescale 1ns/1ps
module obd_prog_tool (
  // Clock
  input  wire       clk,
  // Option programming
  output reg        prog_mode, prog_opt_we, prog_opt_sel, prog_opt_erase,
  output reg  [7:0] prog_opt_data,
  // Erase engine
  input  wire       user_mem_erase,
  output reg        user_mem_erase_done
);
  reg [3:0] lat = 4'h1;
  reg [3:0] cnt = 4'h0;
  initial begin
    {prog_mode, prog_opt_we, prog_opt_sel, prog_opt_erase, user_mem_erase_done} = 5'h0;
    prog_opt_data = 8'h5a;
  end
  // Erase done lat+1 cycles after user_mem_erase goes high
  always @(posedge clk) begin
    cnt <= user_mem_erase ? cnt + 4'h1 : 4'h0;
    user_mem_erase_done <= user_mem_erase && cnt == lat;
  end
  task write_opt(input sel, input [7:0] v);
    begin
      @(posedge clk);
      prog_mode <= 1'b1;
      prog_opt_we <= 1'b1;
      prog_opt_sel <= sel;
      prog_opt_data <= v;
      @(posedge clk);
      prog_mode <= 1'b0;
      prog_opt_we <= 1'b0;
      prog_opt_data <= ~v;
    end
  endtask
  task erase;
    begin
      @(posedge clk);
      prog_mode <= 1'b1;
      prog_opt_erase <= 1'b1;
      @(posedge clk);
      prog_mode <= 1'b0;
      prog_opt_erase <= 1'b0;
    end
  endtask
endmodule // obd_prog_tool

// ### tb/option_byte_config_decoder_test.sv
// Self-checking bench for the option byte decoder
`timescale 1ns/1ps
module option_byte_config_decoder_test;
  reg        clk, reset, avs_read, avs_write, halt_exit, prog_mem_read_req, prog_mem_write_req;
  reg        timer_cmp_out1, timer_cmp_out2, serial2_clk, serial2_tx;
  reg [3:0]  avs_address;
  reg [31:0] avs_writedata, seed, rd;
  reg [7:0]  port_pin_in, o0, o1;
  reg [1:0]  rs;
  wire [31:0] avs_readdata;
  wire [1:0]  avs_response, alt_function_remap, clock_source_sel, osc_freq_range;
  wire [3:0]  clock_range_onehot;
  wire [7:0]  port_pin_out, port_pin_oe, prog_opt_data;
  wire avs_waitrequest, prog_mode, prog_opt_we, prog_opt_sel, prog_opt_erase, user_mem_erase;
  wire user_mem_erase_done, readout_protect_n, ext_read_allow, flash_write_allow, cpu_hold;
  wire reset_delay_sel, clk_src_resonator, clk_src_internal, clk_src_external, clk_src_reserved;
  wire timer_cap_in1, timer_cap_in2, serial2_rx, serial2_avail;
  integer n_errors, checks_done, i, k;
  obd_option_decoder dut (.*, .avs_byteenable(4'hf));
  obd_prog_tool tool (.*);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [7:0] legal1(input [7:0] v);
    begin
      legal1 = v;
      legal1[1] = 1'b1;
      if (v[5:4] == 2'h3) legal1[3:2] = 2'h3;
      if (v[5:4] == 2'h0) legal1[0] = 1'b0;
    end
  endfunction
  task give_verdict;
    begin
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task tmo;
    begin
      n_errors = n_errors + 1;
      give_verdict;
    end
  endtask
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        $display("unexpected %0s exp %h got %h", nm, e, g);
        n_errors = n_errors + 1;
      end
    end
  endtask
  task bus(input w, input [3:0] a);
    begin
      @(posedge clk);
      seed = nxt(seed);
      avs_address <= a;
      avs_writedata <= seed;
      avs_write <= w;
      avs_read <= !w;
      k = 0;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && k < 20) begin
        @(posedge clk);
        k = k + 1;
      end
      if (k == 20) tmo;
      rd = avs_readdata;
      rs = avs_response;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask
  task hold_wait(input integer d);
    begin
      k = 0;
      @(negedge clk);
      while (cpu_hold === 1'b1 && k < 5000) begin
        @(negedge clk);
        k = k + 1;
      end
      if (k == 5000) tmo;
      chk("hold", 1, k >= d && k <= d + 2);
    end
  endtask
  task do_reset(input integer d);
    begin
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      hold_wait(d);
    end
  endtask
  task cfg(input [7:0] e0, input [7:0] e1);
    begin
      chk("prot", e0[0], readout_protect_n);
      chk("remap", e1[7:6], alt_function_remap);
      chk("src", e1[5:4], clock_source_sel);
      chk("srcoh", 4'h1 << e1[5:4], {clk_src_external, clk_src_internal, clk_src_reserved, clk_src_resonator});
      chk("rng", e1[3:2], osc_freq_range);
      chk("rngoh", 4'h1 << e1[3:2], clock_range_onehot);
      chk("reset_delay_sel", e1[0], reset_delay_sel);
      bus(1'b1, 4'h0);
      chk("wresp", 2'h2, rs);
      bus(1'b0, 4'h0);
      chk("opt0", e0, rd);
      bus(1'b0, 4'h4);
      chk("opt1", e1, rd);
    end
  endtask
  task pins;
    begin
      seed = nxt(seed);
      port_pin_in <= seed[7:0];
      {timer_cmp_out1, timer_cmp_out2, serial2_clk, serial2_tx} <= seed[11:8];
      prog_mem_read_req <= 1'b1;
      prog_mem_write_req <= 1'b1;
      repeat (8) @(posedge clk);
      chk("xrd", o0[0], ext_read_allow);
      chk("fwr", o0[0], flash_write_allow);
      chk("cap1", o1[7] ? seed[6] : seed[2], timer_cap_in1);
      chk("cap2", o1[6] ? seed[7] : seed[0], timer_cap_in2);
      chk("d3", o1[7] ? seed[9] : seed[11], port_pin_out[1]);
      chk("d5", o1[7] ? seed[8] : seed[10], port_pin_out[3]);
      chk("avail", o1[7], serial2_avail);
      chk("oe", o1[7] ? 8'h3a : 8'h0a, port_pin_oe);
      if (o1[7]) begin
        chk("b6", seed[11], port_pin_out[4]);
        chk("b7", seed[10], port_pin_out[5]);
        chk("rx", seed[2], serial2_rx);
      end
    end
  endtask
  initial begin
    n_errors = 0;
    checks_done = 0;
    seed = 32'h23b7;
    {reset, avs_read, avs_write, halt_exit, prog_mem_read_req, prog_mem_write_req} = 6'h20;
    {timer_cmp_out1, timer_cmp_out2, serial2_clk, serial2_tx} = 4'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    port_pin_in = 8'h0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    hold_wait(256);
    cfg(8'hff, 8'hef);
    for (i = 0; i < 6; i = i + 1) begin
      seed = nxt(seed);
      o1 = legal1(i < 4 ? {i[1:0], i[1:0], i[1:0], seed[1:0]} : seed[7:0]);
      o0 = {seed[15:14], 1'b1, seed[12], seed[11] | (o1[3:2] != 2'h1), 2'h3, i != 3};
      tool.write_opt(1'b1, o1);
      tool.write_opt(1'b0, o0);
      do_reset(o1[0] ? 256 : 4096);
      cfg(o0, o1);
      pins;
      if (i == 1) begin
        halt_exit <= 1'b1;
        @(posedge clk);
        halt_exit <= 1'b0;
        hold_wait(o1[0] ? 256 : 4096);
      end
      if (i == 3) begin
        tool.write_opt(1'b0, 8'hff);
        do_reset(o1[0] ? 256 : 4096);
        cfg(o0, o1);
        tool.lat = 4'h9;
        tool.erase;
        @(negedge clk);
        chk("erase", 1, user_mem_erase);
        k = 0;
        while (user_mem_erase === 1'b1 && k < 40) begin
          @(negedge clk);
          k = k + 1;
        end
        if (k == 40) tmo;
        do_reset(256);
        cfg(8'hff, 8'hef);
      end
    end
    bus(1'b0, 4'h2);
    chk("unmap", 2'h2, rs);
    bus(1'b1, 4'hc);
    chk("ctl", 2'h0, rs);
    bus(1'b0, 4'hc);
    chk("ctlrd", 1, rd);
    bus(1'b0, 4'h8);
    chk("status", {26'h0, 5'h12, o1[5:4] == 2'h1}, rd);
    give_verdict;
  end
endmodule // option_byte_config_decoder_test
